// ### test/bbs_checker.sv
// Port assertions of the battery-backup supervisor.
`timescale 1ns/1ps
`include "bbs_map.vh"
module bbs_checker #(
    parameter [15:0] TICK_DIV  = 16'h2,
    parameter [11:0] RST_DELAY = 12'h5
) (
    // Clock, reset, comparator decisions
    input wire core_clk, rst_n, mainAboveTrip, mainAboveBatt, monitorAboveRef, monitorAboveHyst,
    // Outputs watched
    input wire resetOut_n, powerFailFlag_n, backedSupplySrc, batteryConnect, sealActive
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic [31:0] lowCnt_q;
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
            lowCnt_q <= 32'h0;
        else
            lowCnt_q <= resetOut_n ? 32'h0 : lowCnt_q + 32'h1;
    end
    property p_flagLow; !monitorAboveRef [*4] |-> !powerFailFlag_n; endproperty
    property p_flagHigh; monitorAboveHyst [*4] |-> powerFailFlag_n; endproperty
    property p_srcBatt;
        (!mainAboveTrip && !mainAboveBatt && !sealActive) [*4] |-> backedSupplySrc == `BBS_SRC_BATT;
    endproperty
    property p_srcMain; (mainAboveTrip || mainAboveBatt) [*4] |-> backedSupplySrc == `BBS_SRC_MAIN; endproperty
    property p_rstLow; !mainAboveTrip [*4] |-> !resetOut_n; endproperty
    property p_rstDelay; $rose(resetOut_n) |-> lowCnt_q >= (RST_DELAY - 1) * TICK_DIV; endproperty
    property p_sealIso; sealActive |-> !batteryConnect; endproperty
    property p_sealExit; $rose(resetOut_n) |-> ##[0:1] !sealActive; endproperty
    a_flagLow: assert property (p_flagLow) else $error("flag high below ref");
    a_flagHigh: assert property (p_flagHigh) else $error("flag low above hyst");
    a_srcBatt: assert property (p_srcBatt) else $error("source not battery");
    a_srcMain: assert property (p_srcMain) else $error("source not main");
    a_rstLow: assert property (p_rstLow) else $error("reset high below trip");
    a_rstDelay: assert property (p_rstDelay) else $error("reset delay short");
    a_sealIso: assert property (p_sealIso) else $error("battery on while sealed");
    a_sealExit: assert property (p_sealExit) else $error("seal kept after reset rise");
    c_seal: cover property ($rose(sealActive));
    c_batt: cover property ($rose(backedSupplySrc));
    c_rel: cover property ($rose(resetOut_n));
endmodule // bbs_checker

// ### test/bbs_host_model.sv
// Host processor model that kicks the watchdog pin.
`timescale 1ns/1ps
module bbs_host_model (
    // Clock and mode: 0 held low, 1 pulsing, 2 pin left open
    input wire logic       core_clk,
    input wire logic [1:0] kickMode,
    // Kick pin
    input wire logic       watchdogKickOut, watchdogKickOe,
    output logic           watchdogKickIn, watchdogKickFloating
);
    logic [4:0] cnt_q = 5'h0;
    logic       lvl_q = 1'b0;
    always @(posedge core_clk) begin
        cnt_q <= cnt_q + 5'h1;
        lvl_q <= kickMode == 2'h1 && cnt_q == 5'h0;
    end
    assign watchdogKickFloating = kickMode == 2'h2;
    assign watchdogKickIn = watchdogKickOe ? watchdogKickOut : lvl_q;
endmodule // bbs_host_model

// ### test/tb_top.sv
// Self-checking testbench of the battery-backup supervisor.
`timescale 1ns/1ps
module tb_top;
    logic core_clk = 0, rst_n = 0, mainAboveTrip = 0, mainAboveBatt = 0, monitorAboveRef = 0;
    logic monitorAboveHyst = 0, monitorTiedMain = 0, powerFailFlagPinIn = 1, seen;
    logic [1:0] kickMode = 2'h0;
    wire resetOut_n, powerFailFlag_n, backedSupplySrc, batteryConnect, sealActive;
    wire watchdogKickOut, watchdogKickOe, watchdogKickIn, watchdogKickFloating;
    int miscompares = 0, cmp_count = 0, cycles = 0;
    always #10 core_clk = ~core_clk;
    bbs_supervisor #(
        .TICK_DIV    (16'h0002),
        .SEAL_MIN    (12'h002),
        .SEAL_MAX    (12'h008),
        .WDT_TIMEOUT (12'h028),
        .RST_DELAY   (12'h005)
    ) i_bbs_supervisor (
        .core_clk             (core_clk),
        .rst_n                (rst_n),
        .mainAboveTrip        (mainAboveTrip),
        .mainAboveBatt        (mainAboveBatt),
        .monitorAboveRef      (monitorAboveRef),
        .monitorAboveHyst     (monitorAboveHyst),
        .monitorTiedMain      (monitorTiedMain),
        .watchdogKickIn       (watchdogKickIn),
        .watchdogKickFloating (watchdogKickFloating),
        .powerFailFlagPinIn   (powerFailFlagPinIn),
        .resetOut_n           (resetOut_n),
        .powerFailFlag_n      (powerFailFlag_n),
        .backedSupplySrc      (backedSupplySrc),
        .batteryConnect       (batteryConnect),
        .sealActive           (sealActive),
        .watchdogKickOut      (watchdogKickOut),
        .watchdogKickOe       (watchdogKickOe)
    );
    bbs_host_model i_bbs_host_model (
        .core_clk             (core_clk),
        .kickMode             (kickMode),
        .watchdogKickOut      (watchdogKickOut),
        .watchdogKickOe       (watchdogKickOe),
        .watchdogKickIn       (watchdogKickIn),
        .watchdogKickFloating (watchdogKickFloating)
    );
    task automatic chk(string n, logic e, logic g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s exp %b got %b", n, e, g);
        end
    endtask
    task automatic wt(int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic wrst(logic v);
        repeat (60) if (resetOut_n !== v) wt(1);
        chk("reset", v, resetOut_n);
    endtask
    task automatic flg(logic r, logic h, logic e);
        {monitorAboveRef, monitorAboveHyst} <= {r, h};
        wt(6);
        chk("flag", e, powerFailFlag_n);
    endtask
    task automatic supply_table;
        logic [1:0] seq[5] = '{2'h0, 2'h1, 2'h0, 2'h2, 2'h3};
        for (int i = 0; i < 5; i++) begin
            {mainAboveTrip, mainAboveBatt} <= seq[i];
            wt(6);
            chk("source", seq[i] == 2'h0, backedSupplySrc);
            chk("reset", 1'b0, resetOut_n);
        end
        wrst(1'b1);
    endtask
    task automatic watchdog_runs;
        repeat (200) begin
            wt(1);
            chk("reset kicked", 1'b1, resetOut_n);
        end
        chk("kick drive", 1'b0, watchdogKickOe);
        kickMode <= 2'h0;
        wt(40);
        chk("reset early", 1'b1, resetOut_n);
        wrst(1'b0);
        wrst(1'b1);
    endtask
    task automatic floating_kick;
        int last;
        int gap;
        kickMode <= 2'h2;
        seen = 1'b0;
        last = 0;
        gap = 0;
        for (int i = 1; i <= 300; i++) begin
            wt(1);
            seen |= watchdogKickIn === 1'b1;
            if (watchdogKickOut === 1'b1) begin
                gap = (last > 0) ? i - last : 0;
                last = i;
            end
            chk("reset floating", 1'b1, resetOut_n);
        end
        chk("kick pulse", 1'b1, seen);
        chk("kick drive", 1'b1, watchdogKickOe);
        // Pulses repeat at 7/8 of 40 ticks of 2 clocks, always before the 80-clock timeout.
        chk("kick gap", 1'b1, gap >= 70 && gap < 80);
        kickMode <= 2'h1;
    endtask
    task automatic seal_entry;
        {mainAboveTrip, powerFailFlagPinIn, monitorTiedMain} <= 3'h1;
        wt(10);
        mainAboveTrip <= 1'b1;
        wt(7);
        {mainAboveTrip, mainAboveBatt} <= 2'h0;
        wt(6);
        chk("seal", 1'b1, sealActive);
        chk("battery", 1'b0, batteryConnect);
        chk("source", 1'b0, backedSupplySrc);
        {mainAboveTrip, powerFailFlagPinIn, monitorTiedMain} <= 3'h6;
        wrst(1'b1);
        wt(2);
        chk("seal", 1'b0, sealActive);
    endtask
    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles > 4000) begin
            miscompares++;
            report_and_stop();
        end
    end
    initial begin
        kickMode <= 2'h1;
        wt(5);
        rst_n <= 1'b1;
        {mainAboveTrip, mainAboveBatt} <= 2'h3;
        wt(8);
        chk("reset held", 1'b0, resetOut_n);
        wrst(1'b1);
        flg(1'b1, 1'b0, 1'b0);
        flg(1'b1, 1'b1, 1'b1);
        flg(1'b1, 1'b0, 1'b1);
        flg(1'b0, 1'b0, 1'b0);
        supply_table();
        watchdog_runs();
        floating_kick();
        seal_entry();
        report_and_stop();
    end
endmodule // tb_top
bind bbs_supervisor bbs_checker #(
    .TICK_DIV  (TICK_DIV),
    .RST_DELAY (RST_DELAY)
) i_bbs_checker (
    .core_clk         (core_clk),
    .rst_n            (rst_n),
    .mainAboveTrip    (mainAboveTrip),
    .mainAboveBatt    (mainAboveBatt),
    .monitorAboveRef  (monitorAboveRef),
    .monitorAboveHyst (monitorAboveHyst),
    .resetOut_n       (resetOut_n),
    .powerFailFlag_n  (powerFailFlag_n),
    .backedSupplySrc  (backedSupplySrc),
    .batteryConnect   (batteryConnect),
    .sealActive       (sealActive)
);

// ### verilog/bbs_map.vh
// Timing and encoding constants of the battery-backup supervisor.
`ifndef BBS_MAP_VH
`define BBS_MAP_VH
`define BBS_CLK_HZ          50000000
`define BBS_TICK_DIV        50000
`define BBS_TICK_US         1000
`define BBS_SEAL_MIN_MS     5
`define BBS_SEAL_MAX_MS     35
`define BBS_WDT_TIMEOUT_MS  800
`define BBS_RST_DELAY_MS    100
`define BBS_FLOAT_NUM       7
`define BBS_FLOAT_DEN       8
`define BBS_SRC_MAIN        1'b0
`define BBS_SRC_BATT        1'b1
`endif

// ### verilog/bbs_supervisor.v
// Control logic of the battery-backup supervisor.
// Operation
// RQ1 - Seal entry: strap, then supply 5-35 ms.
// RQ2 - Sealed battery stays isolated from circuitry.
// RQ3 - Seal ends at reset release edge.
// RQ4 - Flag low when monitor below reference.
// RQ5 - Flag high only above reference plus hysteresis.
// RQ6 - Host toggles kick within watchdog timeout.
// RQ7 - Any kick edge restarts watchdog counter.
// RQ8 - Floating kick disables watchdog via retrigger.
// RQ9 - Floating kick: low 7/8, then pulse.
// RQ10 - Host keeps kick low, pulses within 7/8.
// RQ11 - Main supply failure switches output to battery.
// RQ12 - Battery only when below trip and battery.
// RQ13 - Recovery returns to main on either condition.
// RQ14 - Reset low while supply below trip level.
// RQ15 - Timeout or recovery holds reset delay time.
// RQ16 - Timeouts counted from slow time base.
`timescale 1ns/1ps
`include "bbs_map.vh"
module bbs_supervisor #(
    parameter        CNT_W       = 12,
    parameter [15:0] TICK_DIV    = `BBS_TICK_DIV,
    parameter [11:0] SEAL_MIN    = `BBS_SEAL_MIN_MS * 1000 / `BBS_TICK_US,
    parameter [11:0] SEAL_MAX    = `BBS_SEAL_MAX_MS * 1000 / `BBS_TICK_US,
    parameter [11:0] WDT_TIMEOUT = `BBS_WDT_TIMEOUT_MS * 1000 / `BBS_TICK_US,
    parameter [11:0] RST_DELAY   = `BBS_RST_DELAY_MS * 1000 / `BBS_TICK_US
) (
    // Clock and reset
    input  wire core_clk,
    input  wire rst_n,
    // Comparator decisions (asynchronous)
    input  wire mainAboveTrip,
    input  wire mainAboveBatt,
    input  wire monitorAboveRef,
    input  wire monitorAboveHyst,
    input  wire monitorTiedMain,
    // Watchdog kick pin, open when not driven
    input  wire watchdogKickIn,
    input  wire watchdogKickFloating,
    // Power-fail flag pin, sensed while strapped
    input  wire powerFailFlagPinIn,
    // Outputs
    output reg  resetOut_n,
    output reg  powerFailFlag_n,
    output reg  backedSupplySrc,
    output reg  batteryConnect,
    output reg  sealActive,
    output reg  watchdogKickOut,
    output reg  watchdogKickOe
);
    // Two-flop synchronisers for every pin input.
    // Every level resets low, so a kick pin that idles low gives no false edge after reset.
    reg  [7:0] syncA_q;
    reg  [7:0] syncB_q;
    wire       aboveTrip   = syncB_q[0];
    wire       aboveBatt   = syncB_q[1];
    wire       monAbove    = syncB_q[2];
    wire       monHyst     = syncB_q[3];
    wire       monTied     = syncB_q[4];
    wire       kickLvl     = syncB_q[5];
    wire       kickFloat   = syncB_q[6];
    wire       flagPinLow  = ~syncB_q[7];
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            syncA_q <= 8'h00;
            syncB_q <= 8'h00;
        end else begin
            syncA_q <= {powerFailFlagPinIn, watchdogKickFloating, watchdogKickIn, monitorTiedMain,
                        monitorAboveHyst, monitorAboveRef, mainAboveBatt, mainAboveTrip};
            syncB_q <= syncA_q;
        end
    end

    // Slow time base: one enable pulse per millisecond.
    reg  [15:0] divCnt_q;
    reg         tick_q;
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            divCnt_q <= 16'h0000;
            tick_q   <= 1'b0;
        end else if (divCnt_q == TICK_DIV - 16'h0001) begin
            divCnt_q <= 16'h0000;
            tick_q   <= 1'b1; // RQ16
        end else begin
            divCnt_q <= divCnt_q + 16'h0001;
            tick_q   <= 1'b0;
        end
    end

    // Reset sequencer states.
    // Reset is released only from the delay state, so every release follows a full delay.
    localparam [2:0] ST_LOW   = 3'b001;
    localparam [2:0] ST_DELAY = 3'b010;
    localparam [2:0] ST_RUN   = 3'b100;
    reg  [2:0] state_q;
    reg  [2:0] state_d;

    wire [CNT_W-1:0] rstCnt;
    wire [CNT_W-1:0] wdtCnt;
    wire [CNT_W-1:0] sealCnt;
    reg              kickPrev_q;
    wire             kickEdge = kickLvl ^ kickPrev_q;
    // Internal retrigger pulse at 7/8 of the timeout while the pin floats.
    // The product is formed at full width before the cut, so large timeouts do not wrap.
    localparam [31:0] FLOAT_FULL = (WDT_TIMEOUT * `BBS_FLOAT_NUM) / `BBS_FLOAT_DEN;
    wire [CNT_W-1:0] floatPoint = FLOAT_FULL[CNT_W-1:0];
    wire             floatPulse = kickFloat && (wdtCnt >= floatPoint);
    wire             wdtExpired = (wdtCnt >= WDT_TIMEOUT);
    wire             wdtRestart = (state_q != ST_RUN) || (!kickFloat && kickEdge) || floatPulse; // RQ7 RQ8

    // Both kick edges restart the watchdog; host edges are ignored while the pin floats,
    // so the internal pulse seen back on the pin is not counted a second time.
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            kickPrev_q <= 1'b0;
        end else begin
            kickPrev_q <= kickLvl;
        end
    end

    always @* begin
        state_d = state_q;
        case (state_q)
            ST_LOW: begin
                if (aboveTrip) state_d = ST_DELAY; // RQ15
            end
            ST_DELAY: begin
                if (!aboveTrip) state_d = ST_LOW; // RQ14
                else if (rstCnt >= RST_DELAY) state_d = ST_RUN;
            end
            ST_RUN: begin
                if (!aboveTrip) state_d = ST_LOW; // RQ14
                else if (wdtExpired) state_d = ST_DELAY; // RQ15
            end
            default: state_d = ST_LOW;
        endcase
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_LOW;
        end else begin
            state_q <= state_d;
        end
    end

    bbs_tick_counter #(.WIDTH(CNT_W)) uRstCnt (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .tickEn   (tick_q),
        .restart  (state_q != ST_DELAY),
        .count_q  (rstCnt)
    );
    bbs_tick_counter #(.WIDTH(CNT_W)) uWdtCnt (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .tickEn   (tick_q),
        .restart  (wdtRestart), // RQ16
        .count_q  (wdtCnt)
    );

    // Seal entry: strap held while main supply stays up, then drops within the window.
    wire sealStrap = flagPinLow && monTied;
    reg  sealArm_q;
    bbs_tick_counter #(.WIDTH(CNT_W)) uSealCnt (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .tickEn   (tick_q),
        .restart  (!(aboveTrip && sealStrap)),
        .count_q  (sealCnt)
    );
    wire sealWindowOk = (sealCnt > SEAL_MIN) && (sealCnt < SEAL_MAX);
    wire resetRise    = (state_q == ST_DELAY) && (state_d == ST_RUN);

    // Next seal state. The supply switch uses it, so the battery never closes onto the
    // output in the cycle in which the seal is taken. Set and release cannot meet,
    // since release needs the supply above the trip level and entry needs it below.
    reg  sealActive_d;
    always @* begin
        sealActive_d = sealActive;
        if (resetRise) begin
            sealActive_d = 1'b0; // RQ3
        end else if (sealArm_q && !aboveTrip) begin
            sealActive_d = 1'b1; // RQ1
        end
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sealArm_q  <= 1'b0;
            sealActive <= 1'b0;
        end else begin
            sealArm_q  <= aboveTrip && sealStrap && sealWindowOk;
            sealActive <= sealActive_d;
        end
    end

    // Registered outputs.
    // The battery feeds the output only when main is below both the trip level and the
    // battery; a sealed battery stays isolated and the output keeps the main supply.
    // Between the reference and the hysteresis level the flag keeps its last value.
    wire battSelect = !aboveTrip && !aboveBatt; // RQ12 RQ13
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            resetOut_n      <= 1'b0;
            powerFailFlag_n <= 1'b0;
            backedSupplySrc <= `BBS_SRC_MAIN;
            batteryConnect  <= 1'b0;
            watchdogKickOut <= 1'b0;
            watchdogKickOe  <= 1'b0;
        end else begin
            resetOut_n <= (state_d == ST_RUN); // RQ14 RQ15
            if (!monAbove) begin
                powerFailFlag_n <= 1'b0; // RQ4
            end else if (monHyst) begin
                powerFailFlag_n <= 1'b1; // RQ5
            end
            backedSupplySrc <= (battSelect && !sealActive_d) ? `BBS_SRC_BATT : `BBS_SRC_MAIN; // RQ11
            batteryConnect  <= battSelect && !sealActive_d; // RQ2
            watchdogKickOe  <= kickFloat; // RQ9
            watchdogKickOut <= floatPulse; // RQ9
        end
    end
endmodule // bbs_supervisor

// ### verilog/bbs_tick_counter.v
// Millisecond counter clocked by the slow time-base enable.
`timescale 1ns/1ps
module bbs_tick_counter #(
    parameter WIDTH = 12
) (
    // Clock and reset
    input  wire             core_clk,
    input  wire             rst_n,
    // Control
    input  wire             tickEn,
    input  wire             restart,
    // Count
    output reg  [WIDTH-1:0] count_q
);
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= {WIDTH{1'b0}};
        end else if (restart) begin
            count_q <= {WIDTH{1'b0}};
        end else if (tickEn && (count_q != {WIDTH{1'b1}})) begin
            count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end
endmodule // bbs_tick_counter
